// ==== port_cfg_pkg.sv ====
// Shared constants and a threshold function for the FIFO bus port configuration pair.
// Assumes one core clock and an active low asynchronous reset on both ends.
package port_cfg_pkg;

	// Register indices on the configuration port
	localparam logic [1:0] IDX_SERIAL_CMD = 2'h0;
	localparam logic [1:0] IDX_FIFO_THR   = 2'h1;
	localparam logic [1:0] IDX_BUS_MODE   = 2'h2;
	localparam logic [1:0] IDX_TRANSMIT_PARAMETERS   = 2'h3;

	// Reset values
	localparam logic [7:0] RST_SERIAL_CMD = 8'h00;
	localparam logic [7:0] RST_FIFO_THR   = 8'h77;
	localparam logic [7:0] RST_BUS_MODE   = 8'h00;
	localparam logic [7:0] RST_TRANSMIT_PARAMETERS   = 8'h00;

	// Field positions
	localparam int BIT_BACKPRESSURE  = 2;
	localparam int BIT_PAUSE_TRIGGER = 1;
	localparam int TX_THR_HI         = 7;
	localparam int TX_THR_LO         = 4;
	localparam int RX_THR_HI         = 3;
	localparam int RX_THR_LO         = 0;
	localparam int BIT_HEADER_OFF    = 2;
	localparam int BIT_BUS_WIDE      = 1;
	localparam int BIT_BYTE_ORDER    = 0;
	localparam int BIT_RESUME_OFF    = 3;

	// Writable masks; reserved bits read as zero
	localparam logic [7:0] MASK_SERIAL_CMD = 8'h04;
	localparam logic [7:0] MASK_BUS_MODE   = 8'h07;
	localparam logic [7:0] MASK_TRANSMIT_PARAMETERS   = 8'h1f;

	// Threshold granularity is eight bytes
	localparam int THR_SHIFT = 3;
	localparam int LEVEL_W   = 9;
	localparam int FIFO_W    = 64;
	localparam logic [FIFO_W-1:0] LOW_HALF_MASK = 64'h0000_0000_ffff_ffff;

	// Host AHB-Lite register byte offsets
	localparam logic [7:0] HOFF_CMD     = 8'h00;
	localparam logic [7:0] HOFF_STATUS  = 8'h04;
	localparam logic [7:0] HOFF_DATA_LO = 8'h08;
	localparam logic [7:0] HOFF_DATA_HI = 8'h0c;

	// Host command word fields
	localparam int CMD_DATA_HI = 7;
	localparam int CMD_IDX_HI  = 9;
	localparam int CMD_IDX_LO  = 8;
	localparam int CMD_WRITE   = 16;

	// Host status word fields
	localparam int ST_BUSY  = 0;
	localparam int ST_TXRDY = 1;
	localparam int ST_RXRDY = 2;
	localparam int ST_RD_LO = 8;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	// Effective byte threshold for a four-bit field: 8 x (field + 1)
	function automatic logic [LEVEL_W-1:0] thr_bytes(input logic [3:0] fld);
		thr_bytes = LEVEL_W'({1'b0, fld} + 5'h01) << THR_SHIFT;
	endfunction

endpackage

// ==== port_cfg_if.sv ====
// Link between the port configuration logic and the host-side FIFO logic.
// Assumes both ends share hclk; the bench joins them through this interface.
`timescale 1ns/1ps
interface port_cfg_if;
	import port_cfg_pkg::*;

	logic [1:0]        cfg_idx;
	logic              cfg_wr;
	logic              cfg_rd;
	logic [7:0]        cfg_wdata;
	logic [7:0]        cfg_rdata;
	logic              cfg_ack;
	logic              txrdy;
	logic              rxrdy;
	logic [FIFO_W-1:0] fifo_data;

	modport dev (
		input  cfg_idx,
		input  cfg_wr,
		input  cfg_rd,
		input  cfg_wdata,
		output cfg_rdata,
		output cfg_ack,
		output txrdy,
		output rxrdy,
		output fifo_data
	);

	modport host (
		output cfg_idx,
		output cfg_wr,
		output cfg_rd,
		output cfg_wdata,
		input  cfg_rdata,
		input  cfg_ack,
		input  txrdy,
		input  rxrdy,
		input  fifo_data
	);
endinterface

// ==== port_cfg_dev.sv ====
// Per-port configuration registers, FIFO ready strobes and flow control.
// Assumes the host keeps one access at a time and programs no zero field.
//
// Summary of operation
// RL1: Half-duplex collision with backpressure starts transmission
// RL2: Trigger bit sends one pause frame, full-duplex
// RL3: Software triggers pause only with resume frames off; pause_send here ignores the resume-off bit
// RL4: Txrdy when free space >= 8*(field+1)
// RL5: Rxrdy when fill >= 8*(field+1)
// RL6: Header raises rxrdy unless header-ready is off
// RL7: Wide mode uses 64 bits, else 32
// RL8: Byte order bit selects big or little endian
// RL9: Resume frame off blocks frame on deassertion
// RL10: Ready strobes drop when conditions stop holding
`timescale 1ns/1ps
module port_cfg_dev
	import port_cfg_pkg::*;
(
	input  wire logic              hclk,
	input  wire logic              hresetn,
	port_cfg_if.dev                link,
	input  wire logic [LEVEL_W-1:0] tx_free_bytes,
	input  wire logic [LEVEL_W-1:0] rx_fill_bytes,
	input  wire logic              rx_header_present,
	input  wire logic              full_duplex,
	input  wire logic              rx_collision,
	input  wire logic              flow_ctrl_in,
	input  wire logic [FIFO_W-1:0] rx_word,
	output logic                   backpressure_tx_start,
	output logic                   pause_frame_send,
	output logic                   resume_frame_send,
	output logic                   bus_wide_sel,
	output logic                   byte_order_sel
);

	typedef struct packed {
		logic [7:0]        serial_command_bits;
		logic [7:0]        fifo_threshold;
		logic [7:0]        fifo_bus_mode;
		logic [7:0]        transmit_parameters;
		logic [7:0]        rdata;
		logic              ack;
		logic              txrdy;
		logic              rxrdy;
		logic [FIFO_W-1:0] data;
		logic              coll_prev;
		logic              flow_prev;
		logic              bp_start;
		logic              pause_send;
		logic              resume_send;
	} dev_state_t;

	dev_state_t state_reg;
	dev_state_t state_next;

	// Width, then byte order, applied to a bus word
	function automatic logic [FIFO_W-1:0] shape_word(
		input logic [FIFO_W-1:0] w,
		input logic              wide,
		input logic              big
	);
		logic [FIFO_W-1:0] v;
		logic [FIFO_W-1:0] s;
		v = wide ? w : (w & LOW_HALF_MASK);
		s = v;
		if (big) begin
			for (int i = 0; i < 8; i++) begin
				if (wide) begin
					s[8*i +: 8] = v[8*(7-i) +: 8];
				end else if (i < 4) begin
					s[8*i +: 8] = v[8*(3-i) +: 8];
				end
			end
		end
		shape_word = s;
	endfunction

	function automatic logic [7:0] read_reg(
		input dev_state_t st,
		input logic [1:0] idx
	);
		case (idx)
			IDX_SERIAL_CMD: read_reg = st.serial_command_bits;
			IDX_FIFO_THR:   read_reg = st.fifo_threshold;
			IDX_BUS_MODE:   read_reg = st.fifo_bus_mode;
			default:        read_reg = st.transmit_parameters;
		endcase
	endfunction

	always_comb begin
		logic pause_trigger;
		logic hdr_ready;
		pause_trigger = 1'b0;
		hdr_ready     = 1'b0;
		state_next = state_reg;
		state_next.ack         = 1'b0;
		state_next.pause_send  = 1'b0;
		state_next.bp_start    = 1'b0;
		state_next.resume_send = 1'b0;

		if (link.cfg_wr) begin
			case (link.cfg_idx)
				IDX_SERIAL_CMD: begin
					state_next.serial_command_bits =
						link.cfg_wdata & MASK_SERIAL_CMD;
					pause_trigger = link.cfg_wdata[BIT_PAUSE_TRIGGER];
				end
				IDX_FIFO_THR: begin
					state_next.fifo_threshold = link.cfg_wdata;
				end
				IDX_BUS_MODE: begin
					state_next.fifo_bus_mode = link.cfg_wdata & MASK_BUS_MODE;
				end
				default: begin
					state_next.transmit_parameters =
						link.cfg_wdata & MASK_TRANSMIT_PARAMETERS;
				end
			endcase
			state_next.ack = 1'b1;
		end else if (link.cfg_rd) begin
			state_next.rdata = read_reg(state_reg, link.cfg_idx);
			state_next.ack   = 1'b1;
		end

		// Trigger bit is not stored; it reads back as zero
		state_next.pause_send = pause_trigger & full_duplex; // RL2

		state_next.coll_prev = rx_collision;
		state_next.bp_start  = rx_collision & ~state_reg.coll_prev &
			state_reg.serial_command_bits[BIT_BACKPRESSURE] &
			~full_duplex; // RL1

		state_next.flow_prev   = flow_ctrl_in;
		state_next.resume_send = ~flow_ctrl_in & state_reg.flow_prev &
			~state_reg.transmit_parameters[BIT_RESUME_OFF]; // RL9

		state_next.txrdy = tx_free_bytes >= thr_bytes(
			state_reg.fifo_threshold[TX_THR_HI:TX_THR_LO]); // RL4 RL10
		hdr_ready = rx_header_present &
			~state_reg.fifo_bus_mode[BIT_HEADER_OFF]; // RL6
		state_next.rxrdy = hdr_ready | (rx_fill_bytes >= thr_bytes(
			state_reg.fifo_threshold[RX_THR_HI:RX_THR_LO])); // RL5 RL10

		state_next.data = shape_word(rx_word,
			state_reg.fifo_bus_mode[BIT_BUS_WIDE],
			state_reg.fifo_bus_mode[BIT_BYTE_ORDER]); // RL7 RL8
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= '0;
			state_reg.serial_command_bits <= RST_SERIAL_CMD;
			state_reg.fifo_threshold      <= RST_FIFO_THR;
			state_reg.fifo_bus_mode       <= RST_BUS_MODE;
			state_reg.transmit_parameters <= RST_TRANSMIT_PARAMETERS;
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	assign link.cfg_rdata         = state_reg.rdata;
	assign link.cfg_ack           = state_reg.ack;
	assign link.txrdy             = state_reg.txrdy;
	assign link.rxrdy             = state_reg.rxrdy;
	assign link.fifo_data         = state_reg.data;
	assign backpressure_tx_start  = state_reg.bp_start;
	assign pause_frame_send       = state_reg.pause_send;
	assign resume_frame_send      = state_reg.resume_send;
	assign bus_wide_sel           = state_reg.fifo_bus_mode[BIT_BUS_WIDE];
	assign byte_order_sel         = state_reg.fifo_bus_mode[BIT_BYTE_ORDER];

endmodule

// ==== port_cfg_host.sv ====
// Host-side controller: AHB-Lite slave that drives the configuration port.
// Assumes a single AHB-Lite master, word transfers only, zero wait states.
`timescale 1ns/1ps
module port_cfg_host
	import port_cfg_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	port_cfg_if.host         link
);

	typedef enum logic [1:0] {H_IDLE, H_REQ, H_WAIT} host_phase_t;

	typedef struct packed {
		host_phase_t       phase;
		logic              wr_pending;
		logic [7:0]        wr_addr;
		logic [1:0]        idx;
		logic              is_write;
		logic [7:0]        wdata;
		logic [7:0]        rd_value;
		logic              cfg_wr;
		logic              cfg_rd;
		logic [31:0]       rdata;
		logic              txrdy;
		logic              rxrdy;
		logic [FIFO_W-1:0] data;
	} host_state_t;

	host_state_t state_reg;
	host_state_t state_next;

	function automatic logic [31:0] read_word(
		input host_state_t st,
		input logic [7:0]  addr
	);
		logic [31:0] w;
		w = 32'h0000_0000;
		case (addr)
			HOFF_STATUS: begin
				w[ST_BUSY]              = st.phase != H_IDLE;
				w[ST_TXRDY]             = st.txrdy;
				w[ST_RXRDY]             = st.rxrdy;
				w[ST_RD_LO +: 8]        = st.rd_value;
			end
			HOFF_DATA_LO: w = st.data[31:0];
			HOFF_DATA_HI: w = st.data[63:32];
			default:      w = 32'h0000_0000;
		endcase
		read_word = w;
	endfunction

	always_comb begin
		logic take;
		take = hsel & hready & (htrans == HTRANS_NONSEQ);
		state_next = state_reg;
		state_next.cfg_wr = 1'b0;
		state_next.cfg_rd = 1'b0;
		state_next.txrdy  = link.txrdy;
		state_next.rxrdy  = link.rxrdy;
		state_next.data   = link.fifo_data;

		// Address phase
		state_next.wr_pending = take & hwrite;
		if (take) begin
			state_next.wr_addr = haddr[7:0];
			if (!hwrite) begin
				state_next.rdata = read_word(state_reg, haddr[7:0]);
			end
		end

		case (state_reg.phase)
			H_IDLE: begin
				// Command write is ignored while an access is in flight
				if (state_reg.wr_pending && state_reg.wr_addr == HOFF_CMD) begin
					state_next.idx      = hwdata[CMD_IDX_HI:CMD_IDX_LO];
					state_next.wdata    = hwdata[CMD_DATA_HI:0];
					state_next.is_write = hwdata[CMD_WRITE];
					state_next.phase    = H_REQ;
				end
			end
			H_REQ: begin
				state_next.cfg_wr = state_reg.is_write;
				state_next.cfg_rd = ~state_reg.is_write;
				state_next.phase  = H_WAIT;
			end
			H_WAIT: begin
				if (link.cfg_ack) begin
					if (!state_reg.is_write) begin
						state_next.rd_value = link.cfg_rdata;
					end
					state_next.phase = H_IDLE;
				end
			end
			default: state_next.phase = H_IDLE;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	assign hrdata         = state_reg.rdata;
	assign hreadyout      = 1'b1;
	assign hresp          = 1'b0;
	assign link.cfg_idx   = state_reg.idx;
	assign link.cfg_wr    = state_reg.cfg_wr;
	assign link.cfg_rd    = state_reg.cfg_rd;
	assign link.cfg_wdata = state_reg.wdata;

endmodule

// ==== port_cfg_monitor.sv ====
// Checker for the config link, ready strobes and port pulses.
// Assumes the bench wires it beside the link and the port inputs.
`timescale 1ns/1ps
module port_cfg_monitor
	import port_cfg_pkg::*;
(
	input wire logic       hclk,
	input wire logic       hresetn,
	input wire logic [1:0] cfg_idx,
	input wire logic       cfg_wr,
	input wire logic       cfg_rd,
	input wire logic [7:0] cfg_wdata,
	input wire logic [7:0] cfg_rdata,
	input wire logic       cfg_ack,
	input wire logic       txrdy,
	input wire logic       rxrdy,
	input wire logic [8:0] tx_free_bytes,
	input wire logic [8:0] rx_fill_bytes,
	input wire logic       rx_header_present,
	input wire logic       full_duplex,
	input wire logic       rx_collision,
	input wire logic       flow_ctrl_in,
	input wire logic       backpressure_tx_start,
	input wire logic       pause_frame_send,
	input wire logic       resume_frame_send
);
	logic [7:0] thr;
	logic       bp, hoff, roff, ex_tx, ex_rx;

	// Shadow of link writes and expected strobes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			thr <= RST_FIFO_THR;
			bp <= 1'b0;
			hoff <= 1'b0;
			roff <= 1'b0;
			ex_tx <= 1'b0;
			ex_rx <= 1'b0;
		end else begin
			if (cfg_wr && cfg_idx == 2'h0)
				bp <= cfg_wdata[2];
			if (cfg_wr && cfg_idx == 2'h1)
				thr <= cfg_wdata;
			if (cfg_wr && cfg_idx == 2'h2)
				hoff <= cfg_wdata[2];
			if (cfg_wr && cfg_idx == 2'h3)
				roff <= cfg_wdata[3];
			ex_tx <= tx_free_bytes >= {1'b0, thr[7:4] + 5'h01, 3'h0};
			ex_rx <= rx_fill_bytes >= {1'b0, thr[3:0] + 5'h01, 3'h0}
				|| (rx_header_present && !hoff);
		end
	end

	////////////////////////////////
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_req;
		cfg_wr || cfg_rd;
	endsequence
	sequence s_ack;
		cfg_ack ##1 !cfg_ack;
	endsequence
	property p_ack; s_req |=> s_ack; endproperty
	a_ack: assert property (p_ack) else $error("ack timing");
	property p_rd;
		cfg_rd && !cfg_wr && cfg_idx == 2'h1 |=> cfg_rdata == thr;
	endproperty
	a_rd: assert property (p_rd) else $error("threshold read");
	property p_bkp;
		$rose(rx_collision) |=>
			backpressure_tx_start == ($past(bp) && !$past(full_duplex));
	endproperty
	a_bkp: assert property (p_bkp) else $error("backpressure");
	property p_pause;
		cfg_wr && cfg_idx == 2'h0 && cfg_wdata[1] |=>
			pause_frame_send == $past(full_duplex);
	endproperty
	a_pause: assert property (p_pause) else $error("pause");
	property p_once; pause_frame_send |=> !pause_frame_send; endproperty
	a_once: assert property (p_once) else $error("pause twice");
	property p_tx; txrdy == ex_tx; endproperty
	a_tx: assert property (p_tx) else $error("txrdy");
	property p_rx; rxrdy == ex_rx; endproperty
	a_rx: assert property (p_rx) else $error("rxrdy");
	property p_res;
		$fell(flow_ctrl_in) |=> resume_frame_send == !$past(roff);
	endproperty
	a_res: assert property (p_res) else $error("resume");
endmodule

// ==== fifo_bus_config_flow_ctrl_test.sv ====
// Self-checking bench for the port configuration pair over AHB-Lite.
// Assumes both ends share a 40 MHz clock and one link.
`timescale 1ns/1ps
module fifo_bus_config_flow_ctrl_test
	import port_cfg_pkg::*;
;
	logic        hclk = 1'b0;
	logic        hresetn, hsel, hwrite, hreadyout, hresp;
	logic        rx_header_present, full_duplex, rx_collision;
	logic        flow_ctrl_in, backpressure_tx_start;
	logic        pause_frame_send, resume_frame_send;
	logic        bus_wide_sel, byte_order_sel;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata, rd, lo;
	logic [63:0] rx_word, ex;
	logic [8:0]  tx_free_bytes, rx_fill_bytes;
	logic [7:0]  mreg [4], msk [4];
	int          num_errors, checks, i, k, n_bp, n_ps, n_rs;

	always #12.5 hclk = ~hclk;

	always @(posedge hclk) begin
		n_bp += int'(backpressure_tx_start === 1'b1);
		n_ps += int'(pause_frame_send === 1'b1);
		n_rs += int'(resume_frame_send === 1'b1);
	end

	port_cfg_if link_if ();
	port_cfg_dev u_port_cfg_dev (.*, .link(link_if));
	port_cfg_host u_port_cfg_host (.*, .hready(hreadyout), .link(link_if));
	port_cfg_monitor u_port_cfg_monitor (.*, .cfg_idx(link_if.cfg_idx),
		.cfg_wr(link_if.cfg_wr), .cfg_rd(link_if.cfg_rd),
		.cfg_wdata(link_if.cfg_wdata), .cfg_rdata(link_if.cfg_rdata),
		.cfg_ack(link_if.cfg_ack), .txrdy(link_if.txrdy),
		.rxrdy(link_if.rxrdy));

	////////////////////////////////
	task automatic chk(input string nm, input logic [63:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic results;
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic tmo(input logic ok);
		if (!ok) begin
			num_errors++;
			results;
		end
	endtask

	task automatic hold;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 99);
		tmo(n < 99);
	endtask

	task automatic ahb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= HTRANS_NONSEQ;
		hold;
		htrans <= 2'h0;
		hwdata <= d;
		hold;
		rd = hrdata;
	endtask

	// Register access through the command and status words
	task automatic cfg(input logic w, input logic [1:0] x,
		input logic [7:0] d);
		int n;
		ahb(1'b1, HOFF_CMD, {15'h0, w, 6'h0, x, d});
		n = 0;
		do begin
			ahb(1'b0, HOFF_STATUS, 32'h0);
			n++;
		end while (rd[ST_BUSY] !== 1'b0 && n < 50);
		tmo(n < 50);
		if (w)
			mreg[x] = d & msk[x];
		else
			chk("reg", rd[ST_RD_LO +: 8], mreg[x]);
	endtask

	////////////////////////////////
	initial begin
		hresetn = 1'b0;
		hsel = 1'b1;
		hsize = 3'h2;
		hwrite = 1'b0;
		htrans = 2'h0;
		haddr = '0;
		hwdata = '0;
		{rx_header_present, full_duplex, rx_collision, flow_ctrl_in} = '0;
		tx_free_bytes = '0;
		rx_fill_bytes = '0;
		rx_word = '0;
		mreg = '{RST_SERIAL_CMD, RST_FIFO_THR, RST_BUS_MODE, RST_TRANSMIT_PARAMETERS};
		msk = '{MASK_SERIAL_CMD, 8'hff, MASK_BUS_MODE, MASK_TRANSMIT_PARAMETERS};
		rd = $urandom(32'h15d3e9e3);
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		for (i = 0; i < 16; i++) begin
			if (i > 3)
				cfg(1'b1, i[1:0], (8'($urandom) & 8'hfd) | 8'h11);
			cfg(1'b0, i[1:0], 8'h0);
		end
		ahb(1'b0, 8'h10, 32'h0);
		chk("unmapped", {hresp, rd}, 0);
		cfg(1'b1, 2'h2, 8'h04);
		rx_header_present <= 1'b1;
		for (i = 1; i < 16; i++) begin
			cfg(1'b1, 2'h1, {i[3:0], i[3:0]});
			for (k = 0; k < 2; k++) begin
				tx_free_bytes <= 9'(8 * i + 7 + k);
				rx_fill_bytes <= 9'(8 * i + 7 + k);
				repeat (3) @(posedge hclk);
				ahb(1'b0, HOFF_STATUS, 32'h0);
				chk("rdy", rd[2:1], {2{k[0]}});
			end
		end
		rx_fill_bytes <= '0;
		for (k = 0; k < 4; k++) begin
			cfg(1'b1, 2'h2, 8'(k));
			rx_word <= {$urandom, $urandom};
			repeat (3) @(posedge hclk);
			ahb(1'b0, HOFF_STATUS, 32'h0);
			chk("hdr", rd[ST_RXRDY], 1'b1);
			chk("mode", {bus_wide_sel, byte_order_sel}, k[1:0]);
			ahb(1'b0, HOFF_DATA_LO, 32'h0);
			lo = rd;
			ahb(1'b0, HOFF_DATA_HI, 32'h0);
			ex = {<<8{rx_word}};
			if (!k[0])
				ex = rx_word;
			if (!k[1])
				ex = {32'h0, k[0] ? ex[63:32] : ex[31:0]};
			chk("fifo", {rd, lo}, ex);
		end
		for (k = 0; k < 2; k++) begin
			full_duplex <= k[0];
			cfg(1'b1, 2'h3, {4'h0, k[0], 3'h0});
			// Half duplex: backpressure on; full duplex: pause trigger
			cfg(1'b1, 2'h0, {5'h0, ~k[0], k[0], 1'b0});
			rx_collision <= 1'b1;
			flow_ctrl_in <= 1'b1;
			repeat (2) @(posedge hclk);
			rx_collision <= 1'b0;
			flow_ctrl_in <= 1'b0;
			repeat (3) @(posedge hclk);
		end
		chk("pulses", {n_bp[7:0], n_ps[7:0], n_rs[7:0]}, 24'h010101);
		results;
	end
endmodule
